/* dv/apb_host.sv */
// Host processor model: one APB master issuing byte-wide I/O cycles.
// Assumes the bench calls xfer; a slave hang is cut after 64 cycles by xfer itself.
module apb_host (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
    end
    // The request is held until pready is seen high or 64 cycles have passed, so a slow slave is served as well.
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

/* dv/iso_input_chk.sv */
// Checker for the isolated input port decoder, bound to its ports.
// Assumes the jumpers hold still while the bus is in use.
module iso_input_chk
    import iso_input_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [BASE_BITS-1:0] base_jumper,
    input wire logic irq,
    input wire logic [CHANNELS-1:0] irq_line
);
    // ************************************************************
    // Bus timing, decode and interrupt line
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    sequence hit_s; setup_s ##0 paddr[31:12] == 20'h0 && paddr[11:5] == ~base_jumper && paddr[1:0] == 2'h0; endsequence
    AST_READY_ONE: assert property (setup_s |=> pready ##1 !pready)
        else $error("ready not one cycle");
    AST_IDLE_QUIET: assert property (!psel |=> !pready)
        else $error("ready while idle");
    AST_LOW_RANGE: assert property (setup_s ##0 paddr[12:10] == 3'h0 |=> pslverr)
        else $error("low address claimed");
    AST_BASE_HIT: assert property (hit_s |=> !pslverr)
        else $error("own block refused");
    AST_ERR_QUIET: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("refused access drives data");
    AST_BYTE_WIDE: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper data bits set");
    AST_UNUSED_ZERO: assert property (hit_s ##0 paddr[4:2] inside {3'h0, 3'h3, 3'h4, 3'h6, 3'h7} |=> prdata == 32'h0)
        else $error("unused offset returns data");
    AST_LINE_QUIET: assert property (!irq && !$past(irq) |-> irq_line == 16'h0)
        else $error("interrupt line without interrupt");
endmodule

bind isolated_input_port_decoder iso_input_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .base_jumper(base_jumper), .irq(irq), .irq_line(irq_line));

/* dv/tb.sv */
// Self-checking bench for the isolated input port decoder.
// Assumes the host model and a base of 300h on the jumpers.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import iso_input_pkg::*;
    typedef struct {logic [31:0] a; logic w; logic [31:0] r; logic e;} row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, erv;
    logic [31:0] paddr, pwdata, prdata, rdv;
    logic [3:0] pstrb;
    logic [15:0] energized = 16'h5A3C;
    logic [15:0] irq_line;
    int err_total = 0;
    int compares = 0;
    // Base 300h: A9, A8 removed, A7..A3 fitted.
    row_t rows[10] = '{'{32'hC04, 0, 32'hC3, 0}, '{32'hC14, 0, 32'hA5, 0}, '{32'hC00, 0, 32'h0, 0},
        '{32'hC0C, 0, 32'h0, 0}, '{32'hC1C, 1, 32'h0, 0}, '{32'h200, 0, 32'h0, 1}, '{32'hC20, 0, 32'h0, 1},
        '{32'hBFC, 0, 32'h0, 1}, '{32'h1004, 0, 32'h1, 0}, '{32'h1000, 0, 32'h0, 0}};
    always #2 pclk = ~pclk;
    // One level jumper, filters on inputs 7 and 15.
    isolated_input_port_decoder #(.FILTER_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .input_energized(energized), .filter_jumper(16'h0101),
        .interrupt_level_jumper(16'h0020), .base_jumper(7'h1F), .irq(irq), .irq_line(irq_line));
    apb_host host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
    // ************************************************************
    // Compare, access, input-change and closing tasks
    // ************************************************************
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [31:0] a, input logic w, input logic [31:0] d);
        host.xfer(a, w, d, rdv, erv);
    endtask
    task automatic flip(input logic [15:0] m, input int n);
        @(posedge pclk);
        energized <= energized ^ m;
        repeat (n) @(posedge pclk);
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge pclk);
        err_total++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge pclk);
        chk_bit(pready, 1'b0);
        chk_bit(irq, 1'b0);
        presetn <= 1'b1;
        repeat (20) @(posedge pclk);
        $display("test reset done");
        foreach (rows[i]) begin
            acc(rows[i].a, rows[i].w, 32'hFF);
            chk_word(rdv, rows[i].r);
            chk_bit(erv, rows[i].e);
        end
        $display("test decode done");
        flip(16'h8181, 3);
        acc(32'hC04, 1'b0, 32'h0);
        chk_word(rdv, 32'hC2);
        acc(32'hC14, 1'b0, 32'h0);
        chk_word(rdv, 32'hA4);
        repeat (16) @(posedge pclk);
        acc(32'hC04, 1'b0, 32'h0);
        chk_word(rdv, 32'h42);
        acc(32'hC14, 1'b0, 32'h0);
        chk_word(rdv, 32'h24);
        $display("test filter done");
        acc(32'hC04, 1'b1, 32'h0);
        acc(32'hC08, 1'b0, 32'h0);
        chk_word(rdv, 32'h0);
        flip(16'h0008, 8);
        chk_bit(irq, 1'b1);
        chk_word({16'h0, irq_line}, 32'h20);
        acc(32'h1004, 1'b1, 32'h0);
        repeat (2) @(posedge pclk);
        chk_bit(irq, 1'b0);
        acc(32'h1000, 1'b0, 32'h0);
        chk_word(rdv, 32'h1);
        acc(32'h1004, 1'b1, 32'h1);
        repeat (2) @(posedge pclk);
        chk_bit(irq, 1'b1);
        acc(32'hC04, 1'b1, 32'h0);
        repeat (2) @(posedge pclk);
        chk_bit(irq, 1'b0);
        acc(32'hC08, 1'b1, 32'h0);
        flip(16'h1000, 8);
        chk_bit(irq, 1'b0);
        acc(32'hC08, 1'b0, 32'h0);
        flip(16'h0008, 8);
        chk_bit(irq, 1'b1);
        acc(32'h1000, 1'b1, 32'h1);
        repeat (2) @(posedge pclk);
        chk_bit(irq, 1'b0);
        $display("test interrupt done");
        final_report();
    end
endmodule

/* rtl/isolated_input_port_decoder.sv */
// Sixteen-channel isolated input port with change-of-state interrupt, reached over APB.
// Assumes jumpers and field inputs are asynchronous pins; the host I/O space is mapped
// onto APB word addresses, one I/O byte per aligned word.
//
// Design decisions made here: the placing of the registers and register access over APB.
module isolated_input_port_decoder
    import iso_input_pkg::*;
#(
    parameter int unsigned FILTER_CYCLES = FILTER_CYCLES_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [CHANNELS-1:0] input_energized,
    input wire logic [CHANNELS-1:0] filter_jumper,
    input wire logic [CHANNELS-1:0] interrupt_level_jumper,
    input wire logic [BASE_BITS-1:0] base_jumper,
    output logic irq,
    output logic [CHANNELS-1:0] irq_line
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    pins_t pins_raw;
    pins_t pins_meta;
    pins_t pins_sync;

    always_comb begin
        pins_raw.energized = input_energized;
        pins_raw.filter = filter_jumper;
        pins_raw.irq_select = interrupt_level_jumper;
        pins_raw.base = base_jumper;
    end

    // Jumpers are synchronised too, since an installer may move them with power on.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_meta <= '0;
            pins_sync <= '0;
        end else begin
            pins_meta <= pins_raw;
            pins_sync <= pins_meta;
        end
    end

    // ************************************************************
    // Per-channel input filter
    // ************************************************************
    logic [CHANNELS-1:0] level;
    logic [CHANNELS-1:0] level_prev;
    localparam logic [FILTER_CNT_W-1:0] FILTER_LAST = FILTER_CNT_W'(FILTER_CYCLES - 1);

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            // Jumper order is reversed within each group of eight.
            localparam int JUMPER = (ch < 8) ? (7 - ch) : (23 - ch);
            logic [FILTER_CNT_W-1:0] cnt;
            logic [FILTER_CNT_W-1:0] next_cnt;
            logic next_level;
            logic slow;

            always_comb begin
                slow = pins_sync.filter[JUMPER];
                next_cnt = '0;
                next_level = level[ch];
                if (pins_sync.energized[ch] != level[ch]) begin
                    if (!slow || cnt == FILTER_LAST) begin
                        next_level = pins_sync.energized[ch];
                    end else begin
                        next_cnt = cnt + 1'b1;
                    end
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt <= '0;
                    level[ch] <= 1'b0;
                end else begin
                    cnt <= next_cnt;
                    level[ch] <= next_level;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_prev <= '0;
        end else begin
            level_prev <= level;
        end
    end

    // ************************************************************
    // Address decode
    // ************************************************************
    decode_t dec;
    logic [IO_ADDR_W-1:0] io_addr;
    logic [BASE_BITS-1:0] expected_base;
    logic base_legal;
    logic upper_zero;

    always_comb begin
        io_addr = paddr[IO_ADDR_LSB +: IO_ADDR_W];
        expected_base = ~pins_sync.base;
        // bases below 100h are never claimed
        base_legal = expected_base >= BASE_MIN;
        upper_zero = (paddr[31:UPPER_ADDR_LSB] == '0) && (paddr[IO_ADDR_LSB-1:0] == '0);
        dec.io_hit = upper_zero && !paddr[LOCAL_PAGE_BIT] && base_legal
            && (io_addr[IO_ADDR_W-1:3] == expected_base);
        dec.local_hit = upper_zero && paddr[LOCAL_PAGE_BIT];
        dec.sel = io_addr[2:0];
    end

    // ************************************************************
    // Bus response
    // ************************************************************
    // The answer is prepared in the setup cycle so that every bus output comes from a
    // flip-flop; pready is already high in the first access cycle, so no wait state is added.
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic setup;
    logic done;
    logic cos_enable;
    logic cos_pending;
    logic cos_mask;

    always_comb begin
        setup = psel && !penable;
        done = psel && penable && pready;
        next_pready = setup;
        next_pslverr = 1'b0;
        next_prdata = '0;
        if (setup) begin
            // unmatched address returns error, no data
            next_pslverr = !(dec.io_hit || dec.local_hit);
            if (!pwrite && dec.io_hit) begin
                unique case (dec.sel)
                    OFF_INPUTS_LO: next_prdata[7:0] = ~level[7:0];
                    OFF_INPUTS_HI: next_prdata[7:0] = ~level[15:8];
                    default: next_prdata = '0;
                endcase
            end else if (!pwrite && dec.local_hit) begin
                unique case (dec.sel)
                    LOCAL_STATUS: next_prdata[STATUS_COS_BIT] = cos_pending;
                    LOCAL_MASK: next_prdata[STATUS_COS_BIT] = cos_mask;
                    default: next_prdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ************************************************************
    // Change-of-state control
    // ************************************************************
    logic next_cos_enable;
    logic next_cos_pending;
    logic next_cos_mask;
    logic next_irq;
    logic [CHANNELS-1:0] next_irq_line;
    logic changed;
    logic clear_req;

    always_comb begin
        next_cos_enable = cos_enable;
        next_cos_mask = cos_mask;
        clear_req = 1'b0;
        changed = |(level ^ level_prev);
        // other offsets fall through with no effect
        if (done && dec.io_hit) begin
            if (dec.sel == OFF_IRQ_CTRL) begin
                next_cos_enable = !pwrite;
            end
            if (pwrite && dec.sel == OFF_INPUTS_LO) begin
                clear_req = 1'b1;
            end
        end
        if (done && dec.local_hit && pwrite && pstrb[0]) begin
            if (dec.sel == LOCAL_STATUS && pwdata[STATUS_COS_BIT]) begin
                clear_req = 1'b1;
            end
            if (dec.sel == LOCAL_MASK) begin
                next_cos_mask = pwdata[STATUS_COS_BIT];
            end
        end
        // A change in the same cycle as a clear wins, so no edge is lost.
        next_cos_pending = (cos_pending && !clear_req) || (cos_enable && changed);
        next_irq = next_cos_pending && next_cos_mask;
        next_irq_line = {CHANNELS{next_irq}} & pins_sync.irq_select;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cos_enable <= ENABLE_RESET;
            cos_pending <= 1'b0;
            cos_mask <= MASK_RESET;
            irq <= 1'b0;
            irq_line <= '0;
        end else begin
            cos_enable <= next_cos_enable;
            cos_pending <= next_cos_pending;
            cos_mask <= next_cos_mask;
            irq <= next_irq;
            irq_line <= next_irq_line;
        end
    end

endmodule

/* shared/iso_input_pkg.sv */
// Constants, field layouts and carrier types for the isolated input port decoder.
// Assumes a 250 MHz APB clock and jumpers and field inputs that arrive as raw pins.
package iso_input_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned FILTER_TIME_US = 4700;
    localparam int unsigned FILTER_CYCLES_DEFAULT = FILTER_TIME_US * CLK_MHZ;
    localparam int unsigned FILTER_CNT_W = 21;

    // ************************************************************
    // Address layout
    // ************************************************************
    localparam int unsigned CHANNELS = 16;
    localparam int unsigned BASE_BITS = 7;
    localparam int unsigned IO_ADDR_W = 10;
    localparam int unsigned IO_ADDR_LSB = 2;
    localparam int unsigned LOCAL_PAGE_BIT = 12;
    localparam int unsigned UPPER_ADDR_LSB = 13;
    localparam int unsigned BLOCK_BYTES = 8;
    localparam logic [BASE_BITS-1:0] BASE_MIN = 7'h20;
    localparam logic [2:0] OFF_INPUTS_LO = 3'h1;
    localparam logic [2:0] OFF_IRQ_CTRL = 3'h2;
    localparam logic [2:0] OFF_INPUTS_HI = 3'h5;
    localparam logic [2:0] LOCAL_STATUS = 3'h0;
    localparam logic [2:0] LOCAL_MASK = 3'h1;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int unsigned STATUS_COS_BIT = 0;
    localparam logic MASK_RESET = 1'b1;
    localparam logic ENABLE_RESET = 1'b0;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic [CHANNELS-1:0] energized;
        logic [CHANNELS-1:0] filter;
        logic [CHANNELS-1:0] irq_select;
        logic [BASE_BITS-1:0] base;
    } pins_t;

    typedef struct packed {
        logic io_hit;
        logic local_hit;
        logic [2:0] sel;
    } decode_t;

endpackage
